// >>> hw/ubs_pkg.sv
// Purpose: Shared constants and types for the USB bridge status block
// Assumes: 250 MHz system clock
// Notes: Register offsets are byte addresses on the plain register port
package ubs_pkg;
    // Register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FLASH_CMD = 8'h08;
    localparam logic [7:0] ADDR_FLASH_DATA = 8'h0C;
    localparam logic [7:0] ADDR_CFG_NV = 8'h10;
    // Control field positions
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_SLEEP_LSB = 1;
    localparam int CTRL_DIV_LSB = 8;
    // Reset values
    localparam logic [31:0] CFG_NV_RST = 32'h0000_0000;
    localparam logic [15:0] DIV_RST = 16'h0003;
    // Count value at which the straps are caught, on the third edge after reset release
    localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;
    // Flash command codes
    localparam logic [1:0] FCMD_ERASE = 2'h1;
    localparam logic [1:0] FCMD_PROGRAM = 2'h2;
    localparam logic [1:0] FCMD_READ = 2'h3;
    // Sleep levels: deepest is the default
    typedef enum logic [1:0] {
        SLP_IDLE = 2'b00,
        SLP_STANDBY = 2'b01,
        SLP_PWR_SAVE = 2'b10,
        SLP_PWR_DOWN = 2'b11
    } ubs_sleep_t;
    // Boot modes decoded from the straps
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_CONFIG = 2'b01,
        MODE_BOOT = 2'b10
    } ubs_mode_t;
    // Strap sample taken after reset release
    typedef struct packed {
        logic jumper_fitted;
        logic button_held;
    } ubs_strap_t;
    // Shared line drive pair
    typedef struct packed {
        logic out;
        logic oe;
    } ubs_pin_t;
    // Boot mode decode used by logic and checks
    function automatic ubs_mode_t decode_mode(ubs_strap_t s);
        if (s.jumper_fitted && s.button_held) begin
            return MODE_BOOT;
        end else if (s.jumper_fitted) begin
            return MODE_CONFIG;
        end
        return MODE_RUN;
    endfunction
endpackage

// >>> hw/ubs_top.sv
// Purpose: Status, sleep and boot mode logic of a USB bridge controller
// Assumes: Straps and USB state arrive from pins, synchronised here
// Notes: Shared clock/status line is open drain in async mode
`timescale 1ns/10ps
module ubs_top (
    input wire logic i_sys_clk, // System clock 250 MHz
    input wire logic i_sys_rst, // Synchronous reset, active high
    input wire logic i_usb_attached, // USB cable present (pin)
    input wire logic i_usb_suspended, // USB bus suspended (pin)
    input wire logic i_usb_enumerated, // USB enumerated (pin)
    input wire logic i_mode_select_jumper_n, // Jumper fitted, active low
    input wire logic i_program_button_n, // Button held, active low
    input wire logic i_shared_sync_clock_line, // Line level read back
    input wire logic [7:0] i_addr, // Register address
    input wire logic [31:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [31:0] o_rdata, // Read data, one cycle after i_rd
    output logic o_shared_sync_clock_line, // Line output value
    output logic o_shared_sync_clock_line_oe, // Line output enable
    output logic o_sleep, // Low-power sleep request
    output logic [1:0] o_sleep_level, // Sleep level in force
    output logic [1:0] o_mode, // Boot mode
    output logic o_status_indicator_led, // Status LED
    output logic o_power_indicator_led, // Power LED
    output logic o_flash_erase, // Erase pulse to flash
    output logic o_flash_program, // Program pulse to flash
    output logic [31:0] o_flash_wdata, // Program data
    output logic o_nv_wr, // Store config to NV memory
    output logic [31:0] o_nv_wdata // Config value to store
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    // Two flops each; only sync_q is read by logic
    always_ff @(posedge i_sys_clk) begin
        meta_q <= {i_usb_attached, i_usb_suspended, i_usb_enumerated,
            ~i_mode_select_jumper_n, ~i_program_button_n,
            i_shared_sync_clock_line};
        sync_q <= meta_q;
    end
    logic usb_att, usb_susp, usb_enum, line_level;
    ubs_pkg::ubs_strap_t strap_now;
    assign usb_att = sync_q[5];
    assign usb_susp = sync_q[4];
    assign usb_enum = sync_q[3];
    assign strap_now.jumper_fitted = sync_q[2];
    assign strap_now.button_held = sync_q[1];
    assign line_level = sync_q[0];

    // ------------------------------------------------------------
    // Strap capture and boot mode
    // ------------------------------------------------------------
    logic [1:0] cap_cnt_q;
    logic strap_done_q;
    ubs_pkg::ubs_mode_t mode_q;
    // Wait for synchroniser to fill before catching straps once
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            mode_q <= ubs_pkg::MODE_RUN;
        end else if (!strap_done_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == ubs_pkg::STRAP_CAPTURE_CNT) begin
                strap_done_q <= 1'b1;
                mode_q <= ubs_pkg::decode_mode(strap_now);
            end
        end
    end
    // LEDs: bootloader lights status and darkens power
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_status_indicator_led <= 1'b0;
            o_power_indicator_led <= 1'b0;
            o_mode <= 2'h0;
        end else begin
            o_mode <= mode_q;
            o_status_indicator_led <= strap_done_q &&
                mode_q == ubs_pkg::MODE_BOOT;
            o_power_indicator_led <= strap_done_q &&
                mode_q != ubs_pkg::MODE_BOOT;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic sync_mode_q;
    ubs_pkg::ubs_sleep_t sleep_sel_q;
    logic [15:0] div_q;
    logic [31:0] cfg_nv_q;
    logic erased_q;
    logic refused_q;
    logic usb_active;
    assign usb_active = usb_att && !usb_susp;
    // Control and NV config writes; NV write accepted only in config mode
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sync_mode_q <= 1'b0;
            sleep_sel_q <= ubs_pkg::SLP_PWR_DOWN;
            div_q <= ubs_pkg::DIV_RST;
            cfg_nv_q <= ubs_pkg::CFG_NV_RST;
            o_nv_wr <= 1'b0;
            o_nv_wdata <= 32'h0000_0000;
        end else begin
            o_nv_wr <= 1'b0;
            if (i_wr && i_addr == ubs_pkg::ADDR_CTRL) begin
                sync_mode_q <= i_wdata[ubs_pkg::CTRL_SYNC_BIT];
                sleep_sel_q <= ubs_pkg::ubs_sleep_t'(
                    i_wdata[ubs_pkg::CTRL_SLEEP_LSB +: 2]);
                div_q <= i_wdata[ubs_pkg::CTRL_DIV_LSB +: 16];
            end
            if (i_wr && i_addr == ubs_pkg::ADDR_CFG_NV &&
                mode_q == ubs_pkg::MODE_CONFIG) begin
                cfg_nv_q <= i_wdata;
                o_nv_wr <= 1'b1;
                o_nv_wdata <= i_wdata;
            end
        end
    end
    // Flash loader: erase must precede programming; reads never answer
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            erased_q <= 1'b0;
            refused_q <= 1'b0;
            o_flash_erase <= 1'b0;
            o_flash_program <= 1'b0;
            o_flash_wdata <= 32'h0000_0000;
        end else begin
            o_flash_erase <= 1'b0;
            o_flash_program <= 1'b0;
            if (i_wr && i_addr == ubs_pkg::ADDR_FLASH_DATA) begin
                o_flash_wdata <= i_wdata;
            end
            if (i_wr && i_addr == ubs_pkg::ADDR_FLASH_CMD &&
                mode_q == ubs_pkg::MODE_BOOT) begin
                if (i_wdata[1:0] == ubs_pkg::FCMD_ERASE) begin
                    erased_q <= 1'b1;
                    refused_q <= 1'b0;
                    o_flash_erase <= 1'b1;
                end else if (i_wdata[1:0] == ubs_pkg::FCMD_PROGRAM) begin
                    o_flash_program <= erased_q;
                    refused_q <= !erased_q;
                end else if (i_wdata[1:0] == ubs_pkg::FCMD_READ) begin
                    refused_q <= 1'b1;
                end
            end
        end
    end
    // Read mux; flash data register reads zero so contents never leave
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                ubs_pkg::ADDR_CTRL: o_rdata <= {8'h00, div_q, 5'h00,
                    sleep_sel_q, sync_mode_q};
                ubs_pkg::ADDR_STATUS: o_rdata <= {22'h000000, line_level,
                    refused_q, erased_q, mode_q, usb_enum, usb_susp,
                    usb_att, o_sleep, strap_done_q};
                ubs_pkg::ADDR_CFG_NV: o_rdata <= cfg_nv_q;
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    // Sleep whenever cable removed or bus suspended
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_sleep <= 1'b0;
            o_sleep_level <= ubs_pkg::SLP_PWR_DOWN;
        end else begin
            o_sleep <= !usb_active;
            o_sleep_level <= sleep_sel_q;
        end
    end

    // ------------------------------------------------------------
    // Shared clock/status line
    // ------------------------------------------------------------
    logic [15:0] div_cnt_q;
    logic sck_q;
    // Serial clock divider; stops and parks low when USB inactive
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !sync_mode_q || !usb_active) begin
            div_cnt_q <= 16'h0000;
            sck_q <= 1'b0;
        end else if (div_cnt_q >= div_q) begin
            div_cnt_q <= 16'h0000;
            sck_q <= ~sck_q;
        end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
        end
    end
    // Async: pull low only when ready, else release so pull-up wins
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_shared_sync_clock_line <= 1'b0;
            o_shared_sync_clock_line_oe <= 1'b0;
        end else if (sync_mode_q) begin
            o_shared_sync_clock_line <= usb_active ? sck_q : 1'b0;
            o_shared_sync_clock_line_oe <= 1'b1;
        end else begin
            o_shared_sync_clock_line <= 1'b0;
            o_shared_sync_clock_line_oe <= usb_active &&
                usb_enum;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Registered outputs lag their causes by one edge, hence the |=>
    a_sleep_follows_usb: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) !usb_active |=> o_sleep)
        else $error("sleep not requested while usb inactive");
    a_sleep_default_deep: assert property (@(posedge i_sys_clk)
        $fell(i_sys_rst) |-> sleep_sel_q == ubs_pkg::SLP_PWR_DOWN)
        else $error("default sleep level not power-down");
    a_line_opendrain: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) !sync_mode_q && o_shared_sync_clock_line_oe
        |-> !o_shared_sync_clock_line)
        else $error("async line driven high");
    a_ready_pulls_low: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) !sync_mode_q && usb_active && usb_enum
        ##1 !sync_mode_q |-> o_shared_sync_clock_line_oe)
        else $error("ready not shown as low");
    a_notready_release: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) !sync_mode_q && !usb_active ##1 !sync_mode_q
        |-> !o_shared_sync_clock_line_oe)
        else $error("not-ready line still driven");
    a_sync_clock_parks: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) sync_mode_q && !usb_active ##1 sync_mode_q
        |-> o_shared_sync_clock_line_oe && !o_shared_sync_clock_line)
        else $error("sync line not held low while inactive");
    a_sync_clock_runs: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) (sync_mode_q && usb_active && div_q == 16'h0)
        [*3] |-> $changed(sck_q))
        else $error("serial clock not toggling");
    // Indicator pair must follow the caught mode in every mode
    a_boot_leds: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) strap_done_q && mode_q == ubs_pkg::MODE_BOOT
        |=> o_status_indicator_led && !o_power_indicator_led)
        else $error("bootloader leds wrong");
    a_run_leds: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) strap_done_q && mode_q != ubs_pkg::MODE_BOOT
        |=> !o_status_indicator_led && o_power_indicator_led)
        else $error("run or config leds wrong");
    // Flash loader: no program pulse without erase, no pulse outside the bootloader
    a_program_needs_erase: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) o_flash_program |-> $past(erased_q))
        else $error("program issued without erase");
    a_flash_boot_only: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) o_flash_erase || o_flash_program
        |-> $past(mode_q) == ubs_pkg::MODE_BOOT)
        else $error("flash pulse outside bootloader");
    a_no_flash_readback: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) $past(i_rd) &&
        $past(i_addr) == ubs_pkg::ADDR_FLASH_DATA |-> o_rdata == 32'h0)
        else $error("flash data read back");
    a_read_cmd_refused: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) i_wr && i_addr == ubs_pkg::ADDR_FLASH_CMD &&
        mode_q == ubs_pkg::MODE_BOOT && i_wdata[1:0] == ubs_pkg::FCMD_READ
        |=> refused_q)
        else $error("flash read command not refused");
    // Stored configuration only changes from configuration mode
    a_nv_store: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) o_nv_wr |-> cfg_nv_q == o_nv_wdata)
        else $error("nv store value mismatch");
    a_nv_config_only: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst) o_nv_wr
        |-> $past(mode_q) == ubs_pkg::MODE_CONFIG)
        else $error("nv store outside configuration mode");
    a_mode_decode: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        !strap_done_q && cap_cnt_q == ubs_pkg::STRAP_CAPTURE_CNT
        |=> mode_q == ubs_pkg::decode_mode($past(strap_now)))
        else $error("boot mode decode wrong");
    c_boot_mode: cover property (@(posedge i_sys_clk)
        mode_q == ubs_pkg::MODE_BOOT && o_flash_program);
    c_config_store: cover property (@(posedge i_sys_clk) o_nv_wr);
    c_sync_clock: cover property (@(posedge i_sys_clk)
        sync_mode_q && $rose(o_shared_sync_clock_line));
    c_sleep_entry: cover property (@(posedge i_sys_clk) $rose(o_sleep));
    c_program_refused: cover property (@(posedge i_sys_clk) $rose(refused_q));
endmodule

// >>> bench/ubs_target_model.sv
// Purpose: Target side of the shared clock/status line
// Assumes: Bridge drives out/oe pair, target owns the pull-up
// Notes: Undriven line without pull-up shows a changing level
`timescale 1ns/10ps
module ubs_target_model (
    input wire logic i_sys_clk, // System clock
    input wire logic i_pin_out, // Bridge drive value
    input wire logic i_pin_oe, // Bridge drive enable
    input wire logic i_pullup_en, // Target pull-up switched on
    output logic o_line, // Resolved line level
    output logic o_ready_seen // Target has seen ready
);
    logic last_q = 1'b0;
    // Resolve the wire; a floating line must not look settled
    always_comb begin
        if (i_pin_oe) begin
            o_line = i_pin_out;
        end else if (i_pullup_en) begin
            o_line = 1'b1;
        end else begin
            o_line = ~last_q;
        end
    end
    always @(posedge i_sys_clk) begin
        last_q <= o_line;
    end
    // Sample only with the pull-up on, low level means ready
    always @(posedge i_sys_clk) begin
        if (i_pullup_en) begin
            o_ready_seen <= ~o_line;
        end
    end
endmodule

// >>> bench/tb.sv
// Purpose: Self-checking bench for the bridge status block
// Assumes: 250 MHz clock, straps held across each reset
// Notes: Pulse outputs are counted, not sampled at one edge
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic att = 1'b0;
    logic sus = 1'b0;
    logic enu = 1'b0;
    logic jumper_n = 1'b1;
    logic btn_n = 1'b1;
    logic pull_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, f_wd, nv_wd, d;
    logic [1:0] slv, mode;
    logic pin_out, pin_oe, sleep, led_s, led_p, f_er, f_pg, nv_wr;
    logic line, ready;
    int err_total = 0;
    int num_checks = 0;
    int er_n = 0;
    int pg_n = 0;
    int nv_n = 0;
    int gap;
    ubs_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_usb_attached(att),
        .i_usb_suspended(sus), .i_usb_enumerated(enu),
        .i_mode_select_jumper_n(jumper_n), .i_program_button_n(btn_n),
        .i_shared_sync_clock_line(line), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_shared_sync_clock_line(pin_out),
        .o_shared_sync_clock_line_oe(pin_oe), .o_sleep(sleep),
        .o_sleep_level(slv), .o_mode(mode), .o_status_indicator_led(led_s),
        .o_power_indicator_led(led_p), .o_flash_erase(f_er),
        .o_flash_program(f_pg), .o_flash_wdata(f_wd), .o_nv_wr(nv_wr),
        .o_nv_wdata(nv_wd));
    ubs_target_model TGT (.i_sys_clk(clk), .i_pin_out(pin_out),
        .i_pin_oe(pin_oe), .i_pullup_en(pull_en), .o_line(line),
        .o_ready_seen(ready));
    initial begin
        forever #2 clk = ~clk;
    end
    // Pulses last one cycle, so tally them every edge
    always @(posedge clk) begin
        if (f_er === 1'b1) er_n++;
        if (f_pg === 1'b1) pg_n++;
        if (nv_wr === 1'b1) nv_n++;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Straps must stand well past the capture edge
    task automatic boot(input logic j, input logic b, input logic [1:0] m,
        input logic s, input logic p);
        @(posedge clk);
        jumper_n <= j;
        btn_n <= b;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_n(8);
        chk(mode, m);
        chk(led_s, s);
        chk(led_p, p);
        chk(slv, 2'h3);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_ready_sleep();
        @(posedge clk);
        att <= 1'b1;
        enu <= 1'b1;
        wait_n(6);
        chk({sleep, pin_oe, line, ready}, 4'h5);
        @(posedge clk);
        enu <= 1'b0;
        wait_n(6);
        chk({sleep, pin_oe, line, ready}, 4'h2);
        @(posedge clk);
        sus <= 1'b1;
        wait_n(6);
        chk(sleep, 1'b1);
        @(posedge clk);
        sus <= 1'b0;
        att <= 1'b0;
        wait_n(6);
        chk({sleep, slv}, 3'h7);
        reg_wr(ubs_pkg::ADDR_CTRL, 32'h0000_0302);
        wait_n(2);
        chk(slv, 2'h1);
    endtask
    // Divider 3 changes level every fourth cycle, divider 0 every cycle
    task automatic t_sync_clock();
        @(posedge clk);
        att <= 1'b1;
        enu <= 1'b1;
        reg_wr(ubs_pkg::ADDR_CTRL, 32'h0000_0307);
        wait_n(6);
        d[0] = pin_out;
        for (int i = 0; i < 20 && pin_out === d[0]; i++) wait_n(1);
        d[0] = pin_out;
        gap = 0;
        for (int i = 0; i < 20 && pin_out === d[0]; i++) begin
            wait_n(1);
            gap++;
        end
        chk(gap, 32'd4);
        chk(pin_oe, 1'b1);
        reg_wr(ubs_pkg::ADDR_CTRL, 32'h0000_0007);
        wait_n(4);
        d[0] = pin_out;
        wait_n(1);
        chk(pin_out, !d[0]);
        wait_n(1);
        chk(pin_out, d[0]);
        @(posedge clk);
        att <= 1'b0;
        wait_n(6);
        for (int i = 0; i < 8; i++) begin
            chk({pin_oe, pin_out}, 2'h2);
            wait_n(1);
        end
    endtask
    task automatic t_nv_store();
        reg_wr(ubs_pkg::ADDR_CFG_NV, 32'hA5A5_0F0F);
        wait_n(2);
        chk(nv_n, 32'd1);
        chk(nv_wd, 32'hA5A5_0F0F);
        reg_rd(ubs_pkg::ADDR_CFG_NV, d);
        chk(d, 32'hA5A5_0F0F);
        reg_rd(8'h20, d);
        chk(d, 32'h0000_0000);
    endtask
    // Program before erase is refused; read-back never answers
    task automatic t_flash();
        reg_wr(ubs_pkg::ADDR_CFG_NV, 32'h0000_00FF);
        reg_wr(ubs_pkg::ADDR_FLASH_DATA, 32'h1234_5678);
        reg_wr(ubs_pkg::ADDR_FLASH_CMD, {30'h0, ubs_pkg::FCMD_PROGRAM});
        reg_rd(ubs_pkg::ADDR_STATUS, d);
        chk(nv_n, 32'd1);
        chk(pg_n, 32'd0);
        chk(d[8], 1'b1);
        reg_wr(ubs_pkg::ADDR_FLASH_CMD, {30'h0, ubs_pkg::FCMD_ERASE});
        reg_wr(ubs_pkg::ADDR_FLASH_CMD, {30'h0, ubs_pkg::FCMD_PROGRAM});
        reg_rd(ubs_pkg::ADDR_STATUS, d);
        chk(er_n, 32'd1);
        chk(pg_n, 32'd1);
        chk(d[8:7], 2'h1);
        chk(f_wd, 32'h1234_5678);
        reg_wr(ubs_pkg::ADDR_FLASH_CMD, {30'h0, ubs_pkg::FCMD_READ});
        reg_rd(ubs_pkg::ADDR_FLASH_DATA, d);
        chk(d, 32'h0);
        chk(er_n, 32'd1);
        chk(pg_n, 32'd1);
        reg_rd(ubs_pkg::ADDR_STATUS, d);
        chk(d[8], 1'b1);
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        boot(1'b1, 1'b1, ubs_pkg::MODE_RUN, 1'b0, 1'b1);
        t_ready_sleep();
        t_sync_clock();
        boot(1'b0, 1'b1, ubs_pkg::MODE_CONFIG, 1'b0, 1'b1);
        t_nv_store();
        boot(1'b0, 1'b0, ubs_pkg::MODE_BOOT, 1'b1, 1'b0);
        t_flash();
        finish_test();
    end
endmodule
